//--- common/aab_pkg.sv
// Constants and types for the accumulator ALU with bit operations
package aab_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned LOC_W    = 7;
  localparam int unsigned POS_W    = 3;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned FILE_N   = 128;

  // Operand and target encodings
  localparam logic        TGT_ACC  = 1'b0;
  localparam logic        TGT_FILE = 1'b1;
  localparam logic [7:0]  ZERO_B   = 8'h00;
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [7:0]  FILE_RST = 8'h00;
  localparam int unsigned NIB_W    = 4;

  // File location read from the I/O pins; writes go to the port output latch
  localparam logic [6:0]  PORT_LOC = 7'h7f;

  // Software register map
  localparam logic [7:0]  ADR_FILE_LAST = 8'h7f;
  localparam logic [7:0]  ADR_ACC       = 8'h80;
  localparam logic [7:0]  ADR_FLAGS     = 8'h81;

  // Flag bit positions in the flag register
  localparam int unsigned FLG_NULL = 0;
  localparam int unsigned FLG_NIB  = 1;
  localparam int unsigned FLG_HIGH = 2;
  localparam int unsigned FLG_W    = 3;
  localparam logic [2:0]  FLG_RST  = 3'h0;

  typedef enum logic [2:0] {
    AAB_ADD_LITERAL_ACC  = 3'b000,
    AAB_ADD_ACC_REG      = 3'b001,
    AAB_AND_LITERAL_ACC  = 3'b010,
    AAB_AND_ACC_REG      = 3'b011,
    AAB_BIT_CLEAR_REG    = 3'b100,
    AAB_BIT_SET_REG      = 3'b101,
    AAB_SKIP_IF_ZERO_BIT = 3'b110,
    AAB_SKIP_IF_ONE_BIT  = 3'b111
  } aab_op_e;

  typedef struct packed {
    aab_op_e           op;
    logic [7:0]        literal;
    logic [6:0]        reg_location;
    logic              target_select;
    logic [2:0]        position_index;
  } aab_instr_s;

  typedef struct packed {
    logic high_overflow;
    logic nibble_overflow;
    logic result_null;
  } aab_flags_s;

endpackage : aab_pkg

//--- verilog/aab_core.sv
// Accumulator ALU executing add, AND, bit set/clear and bit-test skip
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - add_literal_acc adds literal to accumulator, sets three flags
// - add_acc_reg adds accumulator and file register, three flags
// - target_select 0 writes accumulator, 1 writes the file register
// - and_literal_acc ANDs literal into accumulator, result_null only
// - and_acc_reg ANDs with file register, routed by target_select
// - bit_clear_reg zeroes one chosen bit, no flags change
// - bit_set_reg sets one chosen bit, no flags change
// - skip_if_zero_bit discards next instruction when tested bit is zero
// - skip_if_one_bit discards next instruction when tested bit is one
// - Read-modify-write of the port location uses sampled pin values
module aab_core
  import aab_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // Instruction port
  input  wire logic              i_op_valid,
  input  wire aab_instr_s        i_instr,
  output logic                   o_op_discarded,
  output logic                   o_skip_next,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  // Datapath state
  output logic      [DATA_W-1:0] o_acc,
  output aab_flags_s             o_flags,
  // I/O port pins
  input  wire logic [DATA_W-1:0] i_port_pins,
  output logic      [DATA_W-1:0] o_port_latch
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic              rst_meta_ff;
  logic              rst_sync_ff;
  logic [DATA_W-1:0] pin_meta_ff;
  logic [DATA_W-1:0] pin_sync_ff;

  // Reset released through two flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire rst_n = rst_sync_ff;

  // Pins sampled through two flops
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= ZERO_B;
      pin_sync_ff <= ZERO_B;
    end else begin
      pin_meta_ff <= i_port_pins;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [DATA_W-1:0] file_ff [FILE_N];
  logic [DATA_W-1:0] acc_ff;
  aab_flags_s        flags_ff;
  logic              skip_ff;
  logic [DATA_W-1:0] rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Operand fetch
  wire logic       run      = i_op_valid && !skip_ff;
  wire logic [LOC_W-1:0] loc = i_instr.reg_location;
  wire logic       loc_port = (loc == PORT_LOC);
  wire logic [DATA_W-1:0] file_op = loc_port ? pin_sync_ff : file_ff[loc];
  wire logic [DATA_W-1:0] bit_mask = DATA_W'(1) << i_instr.position_index;
  wire logic       test_bit = |(file_op & bit_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic and logic
  wire logic       op_lit   = (i_instr.op == AAB_ADD_LITERAL_ACC) ||
                              (i_instr.op == AAB_AND_LITERAL_ACC);
  wire logic [DATA_W-1:0] b_op = op_lit ? i_instr.literal : file_op;
  wire logic [DATA_W:0] sum_w = {1'b0, acc_ff} + {1'b0, b_op};
  wire logic [NIB_W:0]  nib_w = {1'b0, acc_ff[NIB_W-1:0]} +
                                {1'b0, b_op[NIB_W-1:0]};
  wire logic [DATA_W-1:0] and_w = acc_ff & b_op;

  ////////////////////////////////////////////////////////////////////////////
  // Next state per instruction
  logic [DATA_W-1:0] nxt_acc;
  aab_flags_s        nxt_flags;
  logic              nxt_skip;
  logic              file_we;
  logic [DATA_W-1:0] file_wd;

  always_comb begin
    nxt_acc   = acc_ff;
    nxt_flags = flags_ff;
    nxt_skip  = 1'b0;
    file_we   = 1'b0;
    file_wd   = sum_w[DATA_W-1:0];
    if (run) begin
      case (i_instr.op)
        AAB_ADD_LITERAL_ACC: begin
          nxt_acc                   = sum_w[DATA_W-1:0];
          nxt_flags.high_overflow   = sum_w[DATA_W];
          nxt_flags.nibble_overflow = nib_w[NIB_W];
          nxt_flags.result_null     = (sum_w[DATA_W-1:0] == ZERO_B);
        end
        AAB_ADD_ACC_REG: begin
          if (i_instr.target_select == TGT_FILE) begin
            file_we = 1'b1;
          end else begin
            nxt_acc = sum_w[DATA_W-1:0];
          end
          nxt_flags.high_overflow   = sum_w[DATA_W];
          nxt_flags.nibble_overflow = nib_w[NIB_W];
          nxt_flags.result_null     = (sum_w[DATA_W-1:0] == ZERO_B);
        end
        AAB_AND_LITERAL_ACC: begin
          nxt_acc               = and_w;
          nxt_flags.result_null = (and_w == ZERO_B);
        end
        AAB_AND_ACC_REG: begin
          file_wd = and_w;
          if (i_instr.target_select == TGT_FILE) begin
            file_we = 1'b1;
          end else begin
            nxt_acc = and_w;
          end
          nxt_flags.result_null = (and_w == ZERO_B);
        end
        AAB_BIT_CLEAR_REG: begin
          file_we = 1'b1;
          file_wd = file_op & ~bit_mask;
        end
        AAB_BIT_SET_REG: begin
          file_we = 1'b1;
          file_wd = file_op | bit_mask;
        end
        AAB_SKIP_IF_ZERO_BIT: nxt_skip = !test_bit;
        AAB_SKIP_IF_ONE_BIT:  nxt_skip = test_bit;
        default: nxt_skip = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  wire logic bus_file  = (i_addr <= ADR_FILE_LAST);
  wire logic bus_acc   = (i_addr == ADR_ACC);
  wire logic bus_flags = (i_addr == ADR_FLAGS);
  wire logic [LOC_W-1:0] bus_loc = i_addr[LOC_W-1:0];
  wire logic [DATA_W-1:0] flags_rd =
    {{(DATA_W-FLG_W){1'b0}}, flags_ff.high_overflow,
     flags_ff.nibble_overflow, flags_ff.result_null};
  wire logic [DATA_W-1:0] file_rd =
    (bus_loc == PORT_LOC) ? pin_sync_ff : file_ff[bus_loc];
  wire logic [DATA_W-1:0] nxt_rdata =
    !i_rd     ? ZERO_B :
    bus_file  ? file_rd :
    bus_acc   ? acc_ff :
    bus_flags ? flags_rd : ZERO_B;

  ////////////////////////////////////////////////////////////////////////////
  // File storage; instruction write wins over software write
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < FILE_N; i++) begin
        file_ff[i] <= FILE_RST;
      end
    end else if (file_we) begin
      file_ff[loc] <= file_wd;
    end else if (i_wr && bus_file) begin
      file_ff[bus_loc] <= i_wdata;
    end
  end

  // Accumulator, flags, skip and read data
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff   <= ACC_RST;
      flags_ff <= FLG_RST;
      skip_ff  <= 1'b0;
      rdata_ff <= ZERO_B;
    end else begin
      acc_ff   <= (i_wr && bus_acc && !run) ? i_wdata : nxt_acc;
      flags_ff <= (i_wr && bus_flags && !run) ?
                  {i_wdata[FLG_HIGH], i_wdata[FLG_NIB], i_wdata[FLG_NULL]} :
                  nxt_flags;
      skip_ff  <= skip_ff ? !i_op_valid : nxt_skip;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_op_discarded = i_op_valid && skip_ff;
  assign o_skip_next    = skip_ff;
  assign o_rdata        = rdata_ff;
  assign o_acc          = acc_ff;
  assign o_flags        = flags_ff;
  assign o_port_latch   = file_ff[PORT_LOC];

endmodule : aab_core

`default_nettype wire

//--- sim/aab_core_sva.sv
// Port assertions for the accumulator ALU
`timescale 1ns/1ps
`default_nettype none
module aab_core_sva
  import aab_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_op_valid,
  input wire aab_instr_s  i_instr,
  input wire logic        o_op_discarded,
  input wire logic        o_skip_next,
  input wire logic        i_wr,
  input wire logic [7:0]  o_acc,
  input wire aab_flags_s  o_flags
);
  // Literal sum with carries out of bits 7 and 3
  wire logic [8:0] sum_w = {1'b0, o_acc} + {1'b0, i_instr.literal};
  wire logic [4:0] nib_w = {1'b0, o_acc[3:0]} + {1'b0, i_instr.literal[3:0]};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_take(aab_op_e k);
    i_op_valid && !o_skip_next && i_instr.op == k;
  endsequence
  sequence s_grp(logic [1:0] g);
    i_op_valid && !o_skip_next && i_instr.op[2:1] == g;
  endsequence
  a_add_lit_sum: assert property ( // Sum
    s_take(AAB_ADD_LITERAL_ACC) |=> o_acc == $past(sum_w[7:0]))
    else $error("literal add result wrong");
  a_add_flags: assert property ( // Add flags
    s_take(AAB_ADD_LITERAL_ACC) |=> o_flags ==
      {$past(sum_w[8]), $past(nib_w[4]), $past(sum_w[7:0] == 8'h00)})
    else $error("add flags wrong");
  a_and_lit: assert property ( // Literal and
    s_take(AAB_AND_LITERAL_ACC) |=> o_acc == $past(o_acc & i_instr.literal)
      && o_flags.result_null == (o_acc == 8'h00)
      && $stable(o_flags.high_overflow))
    else $error("literal and wrong");
  a_bitop_quiet: assert property ( // Flags kept
    s_grp(2'b10) |=> $stable(o_flags) && $stable(o_acc))
    else $error("bit op touched acc or flags");
  a_skip_quiet: assert property ( // Test only
    s_grp(2'b11) |=> $stable(o_flags) && $stable(o_acc))
    else $error("bit test touched acc or flags");
  a_discard_when: assert property ( // Discard
    (o_op_discarded == (i_op_valid && o_skip_next)) &&
    (!$rose(o_skip_next) ||
     $past(i_op_valid && i_instr.op[2:1] == 2'b11)))
    else $error("discard flag or skip source wrong");
  a_discard_nop: assert property ( // No effect
    o_op_discarded && !i_wr |=> $stable(o_acc) && $stable(o_flags)
      && !o_skip_next)
    else $error("discarded instruction had effect");
  a_skip_hold: assert property ( // Pending
    o_skip_next && !i_op_valid |=> o_skip_next)
    else $error("pending skip lost while idle");
endmodule : aab_core_sva
bind aab_core aab_core_sva aab_core_sva_inst (.i_clk, .i_reset_n,
  .i_op_valid, .i_instr, .o_op_discarded, .o_skip_next, .i_wr, .o_acc,
  .o_flags);
`default_nettype wire

//--- sim/aab_core_tb.sv
// Self-checking bench for the accumulator ALU
`timescale 1ns/1ps
`default_nettype none
module aab_core_tb
  import aab_pkg::*;
;
  logic       i_clk = 1'b0;
  logic       i_reset_n = 1'b0;
  logic       i_op_valid = 1'b0;
  aab_instr_s i_instr = '0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] i_port_pins = 8'h3c;
  logic [7:0] o_rdata, o_acc, o_port_latch, acc_s, flg_s, got;
  logic       o_op_discarded, o_skip_next, dsc, skp;
  aab_flags_s o_flags;
  logic [10:0] e;
  logic [7:0] av [4] = '{8'hff, 8'h08, 8'h80, 8'h12};
  logic [7:0] kv [4] = '{8'h01, 8'h08, 8'h80, 8'h34};
  int         fails = 0;
  int         n_compared = 0;
  always #12.5 i_clk = ~i_clk;
  aab_core aab_core_inst (.i_clk, .i_reset_n, .i_op_valid, .i_instr,
    .o_op_discarded, .o_skip_next, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_acc, .o_flags, .i_port_pins, .o_port_latch);
  // Expected {high, nibble, null, sum}
  function automatic logic [10:0] addx(input logic [7:0] a, b);
    logic [8:0] s;
    logic [4:0] n;
    s = a + b;
    n = a[3:0] + b[3:0];
    return {s[8], n[4], s[7:0] == 8'h00, s[7:0]};
  endfunction : addx
  task automatic chk(input logic [7:0] g, x);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, x);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    got = o_rdata;
    @(posedge i_clk);
    chk(got, x);
  endtask : rd
  // One instruction, results captured mid-cycle
  task automatic ex(input aab_op_e op, input logic [7:0] k,
                    input logic [6:0] f, input logic [2:0] b);
    i_instr    <= '{op, k, f, b[2], b};
    i_op_valid <= 1'b1;
    @(negedge i_clk);
    dsc = o_op_discarded;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    @(negedge i_clk);
    acc_s = o_acc;
    flg_s = {5'h0, o_flags};
    skp   = o_skip_next;
    @(posedge i_clk);
  endtask : ex
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    repeat (4000) @(posedge i_clk);
    fails++;
    complete_run();
  end
  // Scenarios
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 4; i++) begin
      wr(ADR_ACC, av[i]);
      e = addx(av[i], kv[i]);
      ex(AAB_ADD_LITERAL_ACC, kv[i], 7'h00, 3'h0);
      chk(acc_s, e[7:0]);
      chk(flg_s, {5'h0, e[10:8]});
    end
    wr(8'h05, 8'h7b);
    wr(ADR_ACC, 8'h95);
    e = addx(8'h95, 8'h7b);
    ex(AAB_ADD_ACC_REG, 8'h00, 7'h05, 3'h4);
    chk(acc_s, 8'h95);
    chk(flg_s, {5'h0, e[10:8]});
    rd(8'h05, e[7:0]);
    ex(AAB_ADD_ACC_REG, 8'h00, 7'h05, 3'h0);
    chk(acc_s, 8'ha5);
    wr(ADR_FLAGS, 8'h06);
    wr(ADR_ACC, 8'hf0);
    ex(AAB_AND_LITERAL_ACC, 8'h0f, 7'h00, 3'h0);
    chk(acc_s, 8'h00);
    chk(flg_s, 8'h07);
    wr(ADR_ACC, 8'h3c);
    ex(AAB_AND_ACC_REG, 8'h00, 7'h05, 3'h4);
    chk(acc_s, 8'h3c);
    chk(flg_s, 8'h06);
    rd(8'h05, 8'h10);
    ex(AAB_AND_ACC_REG, 8'h00, 7'h05, 3'h0);
    chk(acc_s, 8'h10);
    chk(flg_s, 8'h06);
    for (int p = 0; p < 8; p++) begin
      ex(AAB_BIT_SET_REG, 8'h00, 7'h20, p[2:0]);
      rd(8'h20, 8'hff >> (7 - p));
    end
    for (int p = 0; p < 8; p++) begin
      ex(AAB_BIT_CLEAR_REG, 8'h00, 7'h20, p[2:0]);
      rd(8'h20, 8'hfe << p);
    end
    chk(flg_s, 8'h06);
    for (int s = 0; s < 4; s++) begin
      wr(8'h21, {7'h0, s[0]});
      wr(ADR_ACC, 8'h40);
      ex(s[1] ? AAB_SKIP_IF_ONE_BIT : AAB_SKIP_IF_ZERO_BIT, 8'h00,
         7'h21, 3'h0);
      chk({7'h0, skp}, {7'h0, s[1] == s[0]});
      ex(AAB_ADD_LITERAL_ACC, 8'h01, 7'h00, 3'h0);
      chk({7'h0, dsc}, {7'h0, s[1] == s[0]});
      chk(acc_s, (s[1] == s[0]) ? 8'h40 : 8'h41);
      chk({7'h0, skp}, 8'h00);
    end
    ex(AAB_BIT_SET_REG, 8'h00, PORT_LOC, 3'h0);
    @(negedge i_clk);
    chk(o_port_latch, 8'h3d);
    // New pin value, let it pass the synchroniser
    @(posedge i_clk);
    i_port_pins <= 8'h81;
    repeat (3) @(posedge i_clk);
    ex(AAB_BIT_SET_REG, 8'h00, PORT_LOC, 3'h1);
    @(negedge i_clk);
    chk(o_port_latch, 8'h83);
    @(posedge i_clk);
    rd({1'b0, PORT_LOC}, 8'h81);
    rd(8'h90, 8'h00);
    complete_run();
  end
endmodule : aab_core_tb
`default_nettype wire
